// File: hw/icache_top.sv
// direct-mapped instruction cache with control registers
module icache_top
  import icache_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic fetch_valid,
  input wire fetch_t fetch_in,
  output logic fetch_ready,
  output logic resp_valid,
  output logic [31:0] resp_data,
  output logic bus_req,
  output bus_cmd_t bus_cmd,
  input wire logic bus_ack,
  input wire logic [31:0] bus_rdata,
  input wire logic ctl_wr,
  input wire logic ctl_rd,
  input wire logic ctl_sel,
  input wire logic [31:0] ctl_wdata,
  output logic [31:0] ctl_rdata,
  input wire logic cache_off_n,
  output logic cache_active
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    fsm_t state;
    logic [ENTRIES-1:0] valid;
    logic ctl_e;
    logic ctl_f;
    logic [IDX_W-1:0] clr_idx;
    fetch_t req;
    logic ready;
    logic resp_valid;
    logic [31:0] resp_data;
    logic bus_req;
    bus_cmd_t bus_cmd;
    logic [31:0] ctl_rdata;
    logic off_s1;
    logic off_s2;
    logic active;
  } state_t;

  localparam state_t STATE_RESET = '{
    state: ST_IDLE,
    valid: '0,
    ctl_e: CTL_E_RESET,
    ctl_f: CTL_F_RESET,
    clr_idx: '0,
    req: '0,
    ready: 1'b1,
    resp_valid: 1'b0,
    resp_data: REG_ZERO,
    bus_req: 1'b0,
    bus_cmd: '0,
    ctl_rdata: REG_ZERO,
    off_s1: 1'b0,
    off_s2: 1'b0,
    active: 1'b0
  };

  state_t q;
  state_t d;

  // ************************************************************
  // array port
  // ************************************************************
  localparam int HALF_W = 16;
  localparam int ADDR_MSB = 31;

  // one shared word picker keeps hit and miss paths in the same order
  function automatic logic [HALF_W-1:0] pick_word(input logic [2*HALF_W-1:0] lw, input logic a1);
    pick_word = a1 ? lw[HALF_W-1:0] : lw[2*HALF_W-1:HALF_W];
  endfunction

  logic we;
  entry_t wentry;
  entry_t rentry;
  logic [IDX_W-1:0] cur_idx;
  logic [TAG_W-1:0] cur_tag;
  logic enabled;
  logic hit;
  logic [HALF_W-1:0] hit_word;

  assign cur_idx = entry_index(q.req.addr);
  assign cur_tag = entry_tag(q.req.addr, q.req.space);
  // pin is sampled through off_s2 only, never the first stage
  assign enabled = q.ctl_e && !q.off_s2;
  assign hit = q.valid[cur_idx] && (rentry.tag == cur_tag);
  // a1 low picks the upper (first) word of the long word
  assign hit_word = pick_word(rentry.data, q.req.addr[WORD_SEL_BIT]);

  icache_store #(
    .DEPTH(ENTRIES),
    .AW(IDX_W)
  ) u_store (
    .clk(clk),
    .clk_en(clk_en),
    .we(we),
    .widx(cur_idx),
    .wentry(wentry),
    .ridx(cur_idx),
    .rentry(rentry)
  );

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    d = q;
    we = 1'b0;
    wentry = '{tag: cur_tag, data: bus_rdata};
    d.off_s1 = !cache_off_n;
    d.off_s2 = q.off_s1;
    d.resp_valid = 1'b0;
    case (q.state)
      ST_IDLE: begin
        if (fetch_valid) begin
          d.req = fetch_in;
          d.state = ST_LOOKUP;
        end
      end
      ST_LOOKUP: begin
        if (enabled && q.req.instr && hit) begin
          d.resp_valid = 1'b1;
          d.resp_data = {{HALF_W{1'b0}}, hit_word};
          d.state = ST_IDLE;
        end else begin
          d.bus_req = 1'b1;
          d.bus_cmd.space = q.req.space;
          if (q.req.instr) begin
            d.bus_cmd.addr = {q.req.addr[ADDR_MSB:IDX_LSB], LW_ALIGN};
          end else begin
            d.bus_cmd.addr = q.req.addr;
          end
          d.state = ST_BUS;
        end
      end
      ST_BUS: begin
        if (bus_ack) begin
          d.bus_req = 1'b0;
          d.resp_valid = 1'b1;
          if (q.req.instr) begin
            d.resp_data = {{HALF_W{1'b0}}, pick_word(bus_rdata, q.req.addr[WORD_SEL_BIT])};
          end else begin
            d.resp_data = bus_rdata;
          end
          // fill only for enabled, unfrozen instruction misses
          if (q.req.instr && enabled && !q.ctl_f) begin
            we = 1'b1;
            d.valid[cur_idx] = 1'b1;
          end
          d.state = ST_IDLE;
        end
      end
      default: begin
        d.state = ST_IDLE;
      end
    endcase
    // invalidation comes after the fill so a clear in the fill cycle wins
    if (ctl_wr) begin
      if (ctl_sel == SEL_CONTROL) begin
        d.ctl_e = ctl_wdata[CTL_E];
        d.ctl_f = ctl_wdata[CTL_F];
        if (ctl_wdata[CTL_C]) begin
          d.valid = '0;
        end
        if (ctl_wdata[CTL_CE]) begin
          d.valid[q.clr_idx] = 1'b0;
        end
      end else if (ctl_sel == SEL_ENTRY) begin
        d.clr_idx = entry_index(ctl_wdata);
      end
    end
    if (ctl_rd) begin
      if (ctl_sel == SEL_CONTROL) begin
        // clear bits are strobes and never stored
        d.ctl_rdata = REG_ZERO;
        d.ctl_rdata[CTL_E] = q.ctl_e;
        d.ctl_rdata[CTL_F] = q.ctl_f;
      end else begin
        d.ctl_rdata = REG_ZERO;
        d.ctl_rdata[IDX_LSB +: IDX_W] = q.clr_idx;
      end
    end
    d.ready = (d.state == ST_IDLE);
    // second stage only: the first stage may still be settling
    d.active = d.ctl_e && !q.off_s2;
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= STATE_RESET;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign fetch_ready = q.ready;
  assign resp_valid = q.resp_valid;
  assign resp_data = q.resp_data;
  assign bus_req = q.bus_req;
  assign bus_cmd = q.bus_cmd;
  assign ctl_rdata = q.ctl_rdata;
  assign cache_active = q.active;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence lookup_s;
    clk_en && q.state == ST_LOOKUP;
  endsequence

  sequence hit_s;
    lookup_s ##0 (enabled && q.req.instr && hit);
  endsequence

  sequence fill_s;
    clk_en && q.state == ST_BUS && bus_ack && q.req.instr && enabled && !q.ctl_f && !ctl_wr;
  endsequence

  hit_no_bus_a: assert property (hit_s |=> resp_valid && !bus_req && q.state == ST_IDLE)
    else $error("hit started a bus cycle");

  miss_aligned_a: assert property (lookup_s ##0 (q.req.instr && !(enabled && hit))
    |=> bus_req && bus_cmd.addr[1:0] == LW_ALIGN)
    else $error("instruction miss not long-word aligned");

  data_bypass_a: assert property (lookup_s ##0 !q.req.instr |=> bus_req && bus_cmd.addr == $past(q.req.addr))
    else $error("data access did not go to the bus");

  fill_valid_a: assert property (fill_s |=> q.valid[$past(cur_idx)])
    else $error("miss fill left entry invalid");

  freeze_keep_a: assert property (clk_en && we |-> !q.ctl_f && enabled && q.req.instr)
    else $error("array written while frozen or disabled");

  clear_all_a: assert property (clk_en && ctl_wr && ctl_sel == SEL_CONTROL && ctl_wdata[CTL_C]
    |=> q.valid == '0)
    else $error("clear-all left a valid bit");

  clear_one_a: assert property (clk_en && ctl_wr && ctl_sel == SEL_CONTROL && ctl_wdata[CTL_CE]
    |=> !q.valid[$past(q.clr_idx)])
    else $error("clear-one left entry valid");

  ctl_read_zero_a: assert property (clk_en && ctl_rd && ctl_sel == SEL_CONTROL
    |=> ctl_rdata[31:CTL_CE] == '0 && ctl_rdata[CTL_E] == $past(q.ctl_e))
    else $error("control read shows dead bits");

  off_disables_a: assert property (lookup_s ##0 q.off_s2 |=> !resp_valid)
    else $error("lookup hit while cache-off asserted");

  keep_entries_a: assert property (clk_en && !ctl_wr && q.state != ST_BUS |=> q.valid == $past(q.valid))
    else $error("valid bits changed without fill or clear");

  entry_read_a: assert property (clk_en && ctl_rd && ctl_sel == SEL_ENTRY |=> ctl_rdata[31:TAG_LSB] == '0
    && ctl_rdata[IDX_LSB-1:0] == '0 && ctl_rdata[IDX_LSB +: IDX_W] == $past(q.clr_idx))
    else $error("entry address read shows reserved bits");

  active_out_a: assert property (clk_en |=> cache_active == (q.ctl_e && !$past(q.off_s2)))
    else $error("cache active flag disagrees with enable and cache-off");

  hold_frozen_a: assert property (!clk_en |=> $stable(q))
    else $error("state moved while clock enable low");
endmodule

// File: inc/icache_pkg.sv
// constants, carriers and helpers of the instruction cache
package icache_pkg;
  // ************************************************************
  // geometry
  // ************************************************************
  localparam int ENTRIES = 64;
  localparam int IDX_W = 6;
  localparam int IDX_LSB = 2;
  localparam int TAG_LSB = 8;
  localparam int ADDR_TAG_W = 24;
  localparam int TAG_W = ADDR_TAG_W + 1;
  localparam int WORD_SEL_BIT = 1;
  localparam int SPACE_TAG_BIT = 2;
  localparam logic [1:0] LW_ALIGN = 2'h0;

  // ************************************************************
  // register layout
  // ************************************************************
  localparam int CTL_E = 0;
  localparam int CTL_F = 1;
  localparam int CTL_CE = 2;
  localparam int CTL_C = 3;
  localparam int CTL_LIVE_W = 4;
  localparam logic SEL_CONTROL = 1'b0;
  localparam logic SEL_ENTRY = 1'b1;
  localparam logic [31:0] REG_ZERO = 32'h0;
  localparam logic CTL_E_RESET = 1'b0;
  localparam logic CTL_F_RESET = 1'b0;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [31:0] addr;
    logic [2:0] space;
    logic instr;
  } fetch_t;

  typedef struct packed {
    logic [TAG_W-1:0] tag;
    logic [31:0] data;
  } entry_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [2:0] space;
  } bus_cmd_t;

  typedef enum logic [1:0] {ST_IDLE, ST_LOOKUP, ST_BUS} fsm_t;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [IDX_W-1:0] entry_index(input logic [31:0] addr);
    entry_index = addr[IDX_LSB +: IDX_W];
  endfunction

  function automatic logic [TAG_W-1:0] entry_tag(input logic [31:0] addr, input logic [2:0] space);
    entry_tag = {addr[TAG_LSB +: ADDR_TAG_W], space[SPACE_TAG_BIT]};
  endfunction
endpackage

// File: hw/icache_store.sv
// tag and data array of the instruction cache
module icache_store
  import icache_pkg::*;
#(
  parameter int DEPTH = ENTRIES,
  parameter int AW = IDX_W
) (
  input wire logic clk,
  input wire logic clk_en,
  input wire logic we,
  input wire logic [AW-1:0] widx,
  input wire entry_t wentry,
  input wire logic [AW-1:0] ridx,
  output entry_t rentry
);
  // ************************************************************
  // array
  // ************************************************************
  // no reset: contents mean nothing until the valid bit says so
  entry_t mem [DEPTH];

  always_ff @(posedge clk) begin
    if (clk_en && we) begin
      mem[widx] <= wentry;
    end
  end

  assign rentry = mem[ridx];
endmodule

// File: bench/mem_model.sv
// external memory model answering the cache's long-word reads
module mem_model
  import icache_pkg::*;
(
  input wire logic clk,
  input wire logic bus_req,
  input wire bus_cmd_t bus_cmd,
  input wire logic [31:0] salt,
  input wire logic [3:0] lat,
  output logic bus_ack,
  output logic [31:0] bus_rdata,
  output int reads,
  output logic [31:0] last_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************************************
  // read responder
  // ************************************************************
  int wait_n;
  function automatic logic [31:0] pattern(input logic [31:0] a);
    pattern = a ^ {a[15:0], a[31:16]} ^ 32'h3c5a_96e1;
  endfunction
  initial begin
    bus_ack = 1'b0;
    bus_rdata = 32'h0;
    reads = 0;
    last_addr = 32'h0;
    wait_n = 0;
  end
  always @(posedge clk) begin
    #1;
    if (bus_ack) begin
      bus_ack = 1'b0;
      // inverse after release so a late sample never matches
      bus_rdata = ~bus_rdata;
    end else if (bus_req) begin
      if (wait_n >= int'(lat)) begin
        wait_n = 0;
        reads++;
        last_addr = bus_cmd.addr;
        bus_ack = 1'b1;
        bus_rdata = pattern(bus_cmd.addr) ^ salt;
      end else begin
        wait_n++;
      end
    end
  end
endmodule

// File: bench/tb_top.sv
// self-checking bench of the instruction cache
module tb_top
  import icache_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************************************
  // signals and instances
  // ************************************************************
  logic clk, arst_n, fetch_valid, fetch_ready, resp_valid, bus_req, bus_ack;
  logic ctl_wr, ctl_rd, ctl_sel, cache_off_n, cache_active, clk_en;
  logic [31:0] resp_data, bus_rdata, ctl_wdata, ctl_rdata, salt;
  logic [3:0] lat;
  fetch_t fetch_in;
  bus_cmd_t bus_cmd;
  int failures, samples_checked, cycles;
  icache_top i_dut (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .fetch_valid(fetch_valid), .fetch_in(fetch_in),
    .fetch_ready(fetch_ready), .resp_valid(resp_valid), .resp_data(resp_data), .bus_req(bus_req),
    .bus_cmd(bus_cmd), .bus_ack(bus_ack), .bus_rdata(bus_rdata), .ctl_wr(ctl_wr), .ctl_rd(ctl_rd),
    .ctl_sel(ctl_sel), .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata), .cache_off_n(cache_off_n),
    .cache_active(cache_active));
  mem_model i_mem (.clk(clk), .bus_req(bus_req), .bus_cmd(bus_cmd), .salt(salt), .lat(lat),
    .bus_ack(bus_ack), .bus_rdata(bus_rdata), .reads(), .last_addr());
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one idle edge after each strobe so back-to-back calls never re-raise it at once
  task automatic wr(input logic s, input logic [31:0] d);
    ctl_sel = s;
    ctl_wdata = d;
    ctl_wr = 1'b1;
    @(posedge clk);
    #1 ctl_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic s, input logic [31:0] e);
    ctl_sel = s;
    ctl_rd = 1'b1;
    @(posedge clk);
    #1 ctl_rd = 1'b0;
    chk(ctl_rdata, e);
    @(posedge clk);
    #1;
  endtask
  // miss says whether a bus read is expected; s is the salt the word was stored with
  task automatic fetch(input logic [31:0] a, input logic [2:0] sp, input logic ins, input logic miss,
                       input logic [31:0] s);
    int n0;
    int n;
    logic [31:0] la, e;
    n0 = i_mem.reads;
    n = 0;
    la = ins ? {a[31:2], 2'h0} : a;
    e = i_mem.pattern(la) ^ s;
    fetch_in = '{addr: a, space: sp, instr: ins};
    fetch_valid = 1'b1;
    @(posedge clk);
    #1 fetch_valid = 1'b0;
    chk({31'h0, fetch_ready}, 32'h0);
    while (n < 100 && resp_valid !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(32'(n), miss ? 32'(lat) + 32'h2 : 32'h1);
    chk({31'h0, fetch_ready}, 32'h1);
    chk(resp_data, ins ? {16'h0, a[1] ? e[15:0] : e[31:16]} : e);
    chk(32'(i_mem.reads - n0), {31'h0, miss});
    if (miss) chk(i_mem.last_addr, la);
    if (miss) chk({29'h0, bus_cmd.space}, {29'h0, sp});
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset_ctl();
    rd(SEL_CONTROL, 32'h0);
    chk({31'h0, cache_active}, 32'h0);
    fetch(32'h1236, 3'h6, 1'b1, 1'b1, salt);
    fetch(32'h1236, 3'h6, 1'b1, 1'b1, salt);
    wr(SEL_CONTROL, 32'hffff_fffd);
    rd(SEL_CONTROL, 32'h1);
    wr(SEL_ENTRY, 32'hffff_ffff);
    rd(SEL_ENTRY, 32'hfc);
    settle();
    chk({31'h0, cache_active}, 32'h1);
  endtask
  task automatic t_lookup();
    lat = 4'h3;
    fetch(32'h1236, 3'h6, 1'b1, 1'b1, salt);
    fetch(32'h1234, 3'h6, 1'b1, 1'b0, salt);
    fetch(32'h1236, 3'h5, 1'b0, 1'b1, salt);
    fetch(32'h1236, 3'h6, 1'b1, 1'b0, salt);
    fetch(32'h1236, 3'h2, 1'b1, 1'b1, salt);
    fetch(32'h1234, 3'h2, 1'b1, 1'b0, salt);
    fetch(32'hff00_1236, 3'h2, 1'b1, 1'b1, salt);
    fetch(32'h1236, 3'h2, 1'b1, 1'b1, salt);
    lat = 4'h0;
  endtask
  task automatic t_freeze_disable();
    salt = 32'h1111_0000;
    wr(SEL_CONTROL, 32'h3);
    fetch(32'h2040, 3'h6, 1'b1, 1'b1, salt);
    fetch(32'h2040, 3'h6, 1'b1, 1'b1, salt);
    wr(SEL_CONTROL, 32'h1);
    fetch(32'h2040, 3'h6, 1'b1, 1'b1, salt);
    salt = 32'h2222_0000;
    wr(SEL_CONTROL, 32'h0);
    fetch(32'h2042, 3'h6, 1'b1, 1'b1, salt);
    wr(SEL_CONTROL, 32'h1);
    fetch(32'h2042, 3'h6, 1'b1, 1'b0, 32'h1111_0000);
  endtask
  task automatic t_cache_off();
    cache_off_n = 1'b0;
    settle();
    chk({31'h0, cache_active}, 32'h0);
    fetch(32'h2040, 3'h6, 1'b1, 1'b1, salt);
    cache_off_n = 1'b1;
    settle();
    fetch(32'h2040, 3'h6, 1'b1, 1'b0, 32'h1111_0000);
  endtask
  task automatic t_clear();
    fetch(32'h4_0080, 3'h6, 1'b1, 1'b1, salt);
    wr(SEL_ENTRY, 32'h2040);
    wr(SEL_CONTROL, 32'h5);
    rd(SEL_CONTROL, 32'h1);
    fetch(32'h4_0080, 3'h6, 1'b1, 1'b0, salt);
    fetch(32'h2040, 3'h6, 1'b1, 1'b1, salt);
    wr(SEL_ENTRY, 32'h4_0080);
    wr(SEL_CONTROL, 32'h6);
    wr(SEL_CONTROL, 32'h1);
    fetch(32'h4_0080, 3'h6, 1'b1, 1'b1, salt);
    wr(SEL_CONTROL, 32'h9);
    fetch(32'h2040, 3'h6, 1'b1, 1'b1, salt);
    fetch(32'h4_0080, 3'h6, 1'b1, 1'b1, salt);
  endtask
  // writes while the clock enable is low must leave every register untouched
  task automatic t_clk_en();
    clk_en = 1'b0;
    wr(SEL_CONTROL, 32'h0);
    wr(SEL_ENTRY, 32'h0);
    clk_en = 1'b1;
    rd(SEL_CONTROL, 32'h1);
    rd(SEL_ENTRY, 32'h80);
  endtask
  task automatic t_mid_reset();
    fetch(32'h4_0080, 3'h6, 1'b1, 1'b0, salt);
    arst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 arst_n = 1'b1;
    rd(SEL_CONTROL, 32'h0);
    wr(SEL_CONTROL, 32'h1);
    fetch(32'h4_0080, 3'h6, 1'b1, 1'b1, salt);
  endtask
  // ************************************************************
  // clock, reset, watchdog and main sequence
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // far beyond the under two hundred cycles the scenarios need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    {arst_n, fetch_valid, ctl_wr, ctl_rd, ctl_sel} = 5'h0;
    fetch_in = '0;
    ctl_wdata = 32'h0;
    cache_off_n = 1'b1;
    clk_en = 1'b1;
    salt = 32'h0;
    lat = 4'h0;
    repeat (16) @(posedge clk);
    #1 arst_n = 1'b1;
    t_reset_ctl();
    t_lookup();
    t_freeze_disable();
    t_cache_off();
    t_clear();
    t_clk_en();
    t_mid_reset();
    test_done();
  end
endmodule
